/* hdl/lvd_cfg.svh */
// Constants of the level detector timing block: offsets, fields, resets, timing.
// Assumes a 100 MHz clock and an 8-bit byte address on the register port.
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH
// Time base
`define LVD_CLK_PERIOD_NS 10
`define LVD_US_NS 1000
`define LVD_CYC_PER_US (`LVD_US_NS / `LVD_CLK_PERIOD_NS)
`define LVD_REFRESH_MS 200
`define LVD_REFRESH_US (`LVD_REFRESH_MS * 1000)
// Register offsets
`define LVD_REG_CTRL 8'h00
`define LVD_REG_TUNE 8'h04
`define LVD_REG_FREQ 8'h08
`define LVD_REG_CMD 8'h0c
`define LVD_REG_UTIME 8'h10
`define LVD_REG_STAT 8'h14
`define LVD_REG_RESULT 8'h18
`define LVD_REG_MTIME 8'h1c
`define LVD_REG_MDTIME 8'h20
`define LVD_REG_RISE 8'h24
`define LVD_REG_FALL 8'h28
`define LVD_REG_TRCNT 8'h2c
`define LVD_REG_DEVFALL 8'h30
`define LVD_REG_TRACE 3'h2
// Field positions
`define LVD_CTRL_PER 0
`define LVD_CTRL_TREN 1
`define LVD_CTRL_DET 3:2
`define LVD_CTRL_USER 4
`define LVD_TUNE_BW 4:0
`define LVD_TUNE_DEMOD 10:8
`define LVD_TUNE_ATT 19:16
`define LVD_CMD_IMM 0
`define LVD_CMD_CONT 1
// Reset values and sizes
`define LVD_RST_UTIME 20'h003e8
`define LVD_TRACE_DEPTH 8
`define LVD_TICK_W 7
`endif

/* hdl/lvd_pkg.sv */
// Types of the level detector timing block.
// Assumes lvd_cfg.svh is on the include path.
`include "lvd_cfg.svh"
package lvd_pkg;
  typedef enum logic [1:0] {LVD_DET_PEAK = 2'h0, LVD_DET_AVG = 2'h1,
    LVD_DET_RMS = 2'h2, LVD_DET_FAST = 2'h3} lvd_det_t;
  typedef enum logic [3:0] {LVD_PH_IDLE = 4'h1, LVD_PH_WIN = 4'h2,
    LVD_PH_CALC = 4'h4, LVD_PH_HOLD = 4'h8} lvd_ph_t;
  typedef enum logic [2:0] {LVD_A_IDLE = 3'h1, LVD_A_DIV = 3'h2, LVD_A_SQRT = 3'h4} lvd_ast_t;
  typedef struct packed {
    lvd_ph_t ph; logic clr_q; logic meas; logic periodic; logic tren; logic user_en;
    lvd_det_t det; logic [4:0] bw; logic [2:0] demod; logic [3:0] att;
    logic [31:0] freq; logic [19:0] utime; logic [19:0] win_cnt; logic [31:0] ref_cnt;
    logic [15:0] peak; logic [15:0] last; logic [15:0] fast; logic [47:0] sum;
    logic [63:0] sumsq; logic [31:0] cnt; logic start; logic [15:0] det_out;
    logic [15:0] result; logic invalid; logic publish;
    logic [`LVD_TRACE_DEPTH-1:0][15:0] trace; logic [2:0] wp; logic [3:0] tcnt;
    logic [31:0] rdata;
  } lvd_state_t;
  typedef struct packed {
    lvd_ast_t st; logic [5:0] n; logic [31:0] d; logic [63:0] na; logic [63:0] nb;
    logic [32:0] ra; logic [32:0] rb; logic [15:0] res; logic [15:0] avg;
    logic [15:0] rms; logic done;
  } lvd_astate_t;
  typedef struct packed {logic [`LVD_TICK_W-1:0] cnt; logic tick;} lvd_tstate_t;
endpackage

/* hdl/lvd_if.sv */
// Carrier between the timing core and its mean and root unit.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface lvd_if;
  logic start;
  logic [47:0] sum;
  logic [63:0] sumsq;
  logic [31:0] cnt;
  logic [15:0] avg;
  logic [15:0] rms;
  logic done;
  modport ctl (output start, sum, sumsq, cnt, input avg, rms, done);
  modport alu (input start, sum, sumsq, cnt, output avg, rms, done);
endinterface

/* hdl/lvd_tick.sv */
// Microsecond enable divider for the settle window and refresh counters.
// Assumes i_restart comes from logic on the same clock.
`timescale 1ns/1ps
`include "lvd_cfg.svh"
module lvd_tick (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_restart,
  output logic o_tick
);
  lvd_pkg::lvd_tstate_t s;
  lvd_pkg::lvd_tstate_t next_s;

  // Restart keeps the first tick a full microsecond after a clear
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (i_restart) begin
      next_s.cnt = '0;
    end else if (s.cnt == `LVD_TICK_W'(`LVD_CYC_PER_US - 1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + `LVD_TICK_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;
endmodule

/* hdl/lvd_arith.sv */
// Mean and root unit: divides both sums by the count, then takes a square root.
// Assumes start is a one-cycle pulse; a new start aborts a running job.
`timescale 1ns/1ps
module lvd_arith (
  input wire logic i_clk,
  input wire logic i_rst,
  lvd_if.alu a
);
  lvd_pkg::lvd_astate_t s;
  lvd_pkg::lvd_astate_t next_s;
  logic [33:0] stp_a;
  logic [33:0] stp_b;
  logic [15:0] cand;
  logic [31:0] cand_sq;

  // One restoring division step, shared by both quotients
  function automatic logic [33:0] lvd_div_step(input logic [32:0] r, input logic b,
      input logic [31:0] d);
    logic [33:0] t;
    logic [33:0] t2;
    t = {r, b};
    t2 = t - {2'h0, d};
    if (t >= {2'h0, d}) begin
      return {t2[32:0], 1'b1};
    end
    return {t[32:0], 1'b0};
  endfunction

  assign stp_a = lvd_div_step(s.ra, s.na[63], s.d);
  assign stp_b = lvd_div_step(s.rb, s.nb[63], s.d);
  assign cand = s.res | (16'h8000 >> s.n[3:0]);
  assign cand_sq = cand * cand;

  // Quotients shift into the numerator registers to save storage
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      lvd_pkg::LVD_A_IDLE: begin
      end
      lvd_pkg::LVD_A_DIV: begin
        next_s.ra = stp_a[33:1];
        next_s.na = {s.na[62:0], stp_a[0]};
        next_s.rb = stp_b[33:1];
        next_s.nb = {s.nb[62:0], stp_b[0]};
        next_s.n = s.n + 6'h1;
        if (s.n == 6'h3f) begin
          next_s.st = lvd_pkg::LVD_A_SQRT;
          next_s.res = '0;
        end
      end
      lvd_pkg::LVD_A_SQRT: begin
        if (cand_sq <= s.nb[31:0]) begin
          next_s.res = cand;
        end
        next_s.n = s.n + 6'h1;
        if (s.n == 6'h0f) begin
          next_s.st = lvd_pkg::LVD_A_IDLE;
          next_s.avg = s.na[15:0];
          next_s.rms = (cand_sq <= s.nb[31:0]) ? cand : s.res;
          next_s.done = 1'b1;
        end
      end
      default: next_s.st = lvd_pkg::LVD_A_IDLE;
    endcase
    // An empty window divides by one, giving zero
    if (a.start) begin
      next_s.st = lvd_pkg::LVD_A_DIV;
      next_s.n = '0;
      next_s.ra = '0;
      next_s.rb = '0;
      next_s.na = {16'h0, a.sum};
      next_s.nb = a.sumsq;
      next_s.d = (a.cnt == 32'h0) ? 32'h1 : a.cnt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
      s.st <= lvd_pkg::LVD_A_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign a.avg = s.avg;
  assign a.rms = s.rms;
  assign a.done = s.done;
endmodule

/* hdl/lvd_timing.sv */
// Level detector timing core: settle window, window detectors, clearing,
// periodic publishing, continuous refresh, trace store and status.
// Assumes samples and scan steps come from logic on the same clock.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "lvd_cfg.svh"
module lvd_timing #(
  parameter int P_REFRESH_US = `LVD_REFRESH_US
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [15:0] i_sample,
  input wire logic i_sample_valid,
  input wire logic i_scan_step,
  output logic [15:0] o_result,
  output logic o_result_invalid,
  output logic o_publish,
  output logic o_measuring,
  output logic o_window
);
  lvd_pkg::lvd_state_t s;
  lvd_pkg::lvd_state_t next_s;
  lvd_if u_if ();
  logic tick;
  logic [15:0] mag;
  logic [31:0] sq;
  logic [19:0] mtime;
  logic [19:0] rise;
  logic [19:0] fall;
  logic wr_ctrl;
  logic wr_tune;
  logic wr_cmd;
  logic par_evt;
  logic clr_evt;
  logic expire;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic lvd_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction
  // Default measuring time per bandwidth index; rows are {avg/rms, peak, fast} in us
  function automatic logic [19:0] lvd_default_time(input logic [4:0] bw,
      input lvd_pkg::lvd_det_t det);
    logic [59:0] row;
    case (bw)
      5'h00, 5'h01: row = {20'h30d40, 20'h7a120, 20'h003e8};
      5'h02: row = {20'h186a0, 20'h61a80, 20'h003e8};
      5'h03: row = {20'h186a0, 20'h30d40, 20'h001f4};
      5'h04, 5'h05: row = {20'h0c350, 20'h186a0, 20'h001f4};
      5'h06, 5'h07, 5'h08, 5'h09: row = {20'h061a8, 20'h0ea60, 20'h000fa};
      5'h0a, 5'h0b: row = {20'h061a8, 20'h0ea60, 20'h0007d};
      5'h0c: row = {20'h02ee0, 20'h07530, 20'h0003f};
      5'h0d: row = {20'h01770, 20'h04e20, 20'h0003f};
      5'h0e: row = {20'h00fa0, 20'h02710, 20'h0003f};
      5'h0f: row = {20'h00bb8, 20'h02710, 20'h0003f};
      5'h10: row = {20'h00bb8, 20'h01388, 20'h00020};
      5'h11: row = {20'h00bb8, 20'h00fa0, 20'h00020};
      5'h12, 5'h13: row = {20'h00bb8, 20'h007d0, 20'h00007};
      5'h14: row = {20'h00bb8, 20'h003e8, 20'h00007};
      5'h15: row = {20'h00bb8, 20'h003e8, 20'h00004};
      5'h16: row = {20'h007d0, 20'h003e8, 20'h00004};
      5'h17: row = {20'h007d0, 20'h003e8, 20'h00002};
      5'h18: row = {20'h003e8, 20'h003e8, 20'h00002};
      5'h19, 5'h1a, 5'h1b: row = {20'h003e8, 20'h003e8, 20'h00001};
      default: row = {20'h003e8, 20'h003e8, 20'h00000};
    endcase
    case (det)
      lvd_pkg::LVD_DET_PEAK: return row[39:20];
      lvd_pkg::LVD_DET_FAST: return row[19:0];
      default: return row[59:40];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules and datapath terms
  lvd_tick u_tick (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_restart(s.clr_q),
    .o_tick(tick)
  );

  lvd_arith u_arith (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .a(u_if)
  );

  // Sums are frozen in the calculation phase, so the unit reads them live
  assign u_if.start = s.start;
  assign u_if.sum = s.sum;
  assign u_if.sumsq = s.sumsq;
  assign u_if.cnt = s.cnt;
  assign mag = i_sample[15] ? 16'(-i_sample) : i_sample;
  assign sq = mag * mag;
  // Default lookup or fixed user time
  assign mtime = s.user_en ? s.utime : lvd_default_time(s.bw, s.det);
  assign expire = (s.ph == lvd_pkg::LVD_PH_WIN) && (s.win_cnt == 20'h0);
  // Rise and fall derived from the user time
  always_comb begin
    rise = 20'h0;
    fall = 20'h0;
    if (s.user_en) begin
      case (s.det)
        lvd_pkg::LVD_DET_PEAK: fall = s.utime;
        lvd_pkg::LVD_DET_FAST: fall = 20'h0;
        default: begin
          rise = s.utime;
          fall = s.utime;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear events
  assign wr_ctrl = i_wr && lvd_hit(i_addr, `LVD_REG_CTRL);
  assign wr_tune = i_wr && lvd_hit(i_addr, `LVD_REG_TUNE);
  assign wr_cmd = i_wr && lvd_hit(i_addr, `LVD_REG_CMD);
  assign par_evt = (i_wr && lvd_hit(i_addr, `LVD_REG_FREQ)) || i_scan_step
    || (wr_tune && (i_wdata[`LVD_TUNE_BW] != s.bw || i_wdata[`LVD_TUNE_DEMOD] != s.demod
    || i_wdata[`LVD_TUNE_ATT] != s.att))
    || (wr_ctrl && (i_wdata[`LVD_CTRL_DET] != s.det || i_wdata[`LVD_CTRL_USER] != s.user_en
    || i_wdata[`LVD_CTRL_PER] != s.periodic))
    || (i_wr && lvd_hit(i_addr, `LVD_REG_UTIME) && s.user_en);
  // Initiate commands and the periodic cycle
  assign clr_evt = par_evt || (wr_cmd && (i_wdata[`LVD_CMD_IMM] || i_wdata[`LVD_CMD_CONT]))
    || (s.ph == lvd_pkg::LVD_PH_HOLD && s.periodic);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.publish = 1'b0;
    next_s.rdata = '0;
    // Clear is applied one cycle late so the window uses the new settings
    next_s.clr_q = clr_evt;
    if (wr_ctrl) begin
      next_s.periodic = i_wdata[`LVD_CTRL_PER];
      next_s.tren = i_wdata[`LVD_CTRL_TREN];
      next_s.det = lvd_pkg::lvd_det_t'(i_wdata[`LVD_CTRL_DET]);
      next_s.user_en = i_wdata[`LVD_CTRL_USER];
    end
    if (wr_tune) begin
      next_s.bw = i_wdata[`LVD_TUNE_BW];
      next_s.demod = i_wdata[`LVD_TUNE_DEMOD];
      next_s.att = i_wdata[`LVD_TUNE_ATT];
    end
    if (i_wr && lvd_hit(i_addr, `LVD_REG_FREQ)) begin
      next_s.freq = i_wdata;
    end
    if (i_wr && lvd_hit(i_addr, `LVD_REG_UTIME)) begin
      next_s.utime = i_wdata[19:0];
    end
    case (s.ph)
      lvd_pkg::LVD_PH_IDLE: begin
      end
      lvd_pkg::LVD_PH_WIN: begin
        if (i_sample_valid) begin
          if (mag > s.peak) begin
            next_s.peak = mag;
          end
          next_s.sum = s.sum + 48'(mag);
          next_s.sumsq = s.sumsq + 64'(sq);
          next_s.cnt = s.cnt + 32'h1;
          next_s.last = mag;
        end
        // Count the window down in microseconds
        if (expire) begin
          next_s.fast = s.last;
          next_s.start = 1'b1;
          next_s.ph = lvd_pkg::LVD_PH_CALC;
        end else if (tick) begin
          next_s.win_cnt = s.win_cnt - 20'h1;
        end
      end
      lvd_pkg::LVD_PH_CALC: begin
        if (u_if.done) begin
          case (s.det)
            lvd_pkg::LVD_DET_PEAK: next_s.det_out = s.peak;
            lvd_pkg::LVD_DET_AVG: next_s.det_out = u_if.avg;
            lvd_pkg::LVD_DET_RMS: next_s.det_out = u_if.rms;
            default: next_s.det_out = s.fast;
          endcase
          next_s.ph = lvd_pkg::LVD_PH_HOLD;
          if (s.periodic) begin
            next_s.result = next_s.det_out;
            next_s.publish = 1'b1;
            next_s.invalid = 1'b0;
            // Append to the trace store, oldest overwritten
            if (s.tren) begin
              next_s.trace[s.wp] = next_s.det_out;
              next_s.wp = s.wp + 3'h1;
              if (s.tcnt != 4'(`LVD_TRACE_DEPTH)) begin
                next_s.tcnt = s.tcnt + 4'h1;
              end
            end
          end
        end
      end
      lvd_pkg::LVD_PH_HOLD: begin
      end
      default: next_s.ph = lvd_pkg::LVD_PH_IDLE;
    endcase
    // Refresh runs in continuous mode only
    if (s.periodic) begin
      next_s.ref_cnt = '0;
    end else if (tick) begin
      if (s.ref_cnt >= 32'(P_REFRESH_US - 1)) begin
        next_s.ref_cnt = '0;
        next_s.result = s.det_out;
        next_s.publish = 1'b1;
      end else begin
        next_s.ref_cnt = s.ref_cnt + 32'h1;
      end
    end
    // Set wins over the publish clear
    if (s.periodic && par_evt) begin
      next_s.invalid = 1'b1;
    end
    // Restart window and empty the peak, sum, square sum and count; last is kept
    if (s.clr_q) begin
      next_s.ph = lvd_pkg::LVD_PH_WIN;
      next_s.win_cnt = mtime;
      next_s.peak = '0;
      next_s.sum = '0;
      next_s.sumsq = '0;
      next_s.cnt = '0;
    end
    // Busy until the window and every calculation end
    next_s.meas = (next_s.ph == lvd_pkg::LVD_PH_WIN) || (next_s.ph == lvd_pkg::LVD_PH_CALC);
    if (i_rd) begin
      case (i_addr)
        `LVD_REG_CTRL: next_s.rdata = {27'h0, s.user_en, s.det, s.tren, s.periodic};
        `LVD_REG_TUNE: next_s.rdata = {12'h0, s.att, 5'h0, s.demod, 3'h0, s.bw};
        `LVD_REG_FREQ: next_s.rdata = s.freq;
        `LVD_REG_UTIME: next_s.rdata = {12'h0, s.utime};
        `LVD_REG_STAT: next_s.rdata = {29'h0, s.ph == lvd_pkg::LVD_PH_WIN, s.invalid, s.meas};
        `LVD_REG_RESULT: next_s.rdata = {16'h0, s.result};
        // Modulation depth follows the level detector
        `LVD_REG_MTIME, `LVD_REG_MDTIME: next_s.rdata = {12'h0, mtime};
        `LVD_REG_RISE: next_s.rdata = {12'h0, rise};
        `LVD_REG_FALL: next_s.rdata = {12'h0, fall};
        `LVD_REG_TRCNT: next_s.rdata = {25'h0, s.wp, s.tcnt};
        `LVD_REG_DEVFALL: next_s.rdata = {12'h0, s.user_en ? s.utime : 20'h0};
        default: begin
          if (i_addr[7:5] == `LVD_REG_TRACE) begin
            next_s.rdata = {16'h0, s.trace[i_addr[4:2]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
      s.ph <= lvd_pkg::LVD_PH_IDLE;
      s.utime <= `LVD_RST_UTIME;
    end else begin
      s <= next_s;
    end
  end
  // Outputs straight from the state register
  assign o_rdata = s.rdata;
  assign o_result = s.result;
  assign o_result_invalid = s.invalid;
  assign o_publish = s.publish;
  assign o_measuring = s.meas;
  assign o_window = s.ph[1]; // One-hot bit of the window phase

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_win_load;
    s.clr_q |=> (s.ph == lvd_pkg::LVD_PH_WIN && s.win_cnt == $past(mtime));
  endproperty
  a_win_load: assert property (p_win_load) else $error("window not reloaded");
  property p_expire;
    (expire && !s.clr_q) |=> (s.ph == lvd_pkg::LVD_PH_CALC && s.start);
  endproperty
  a_expire: assert property (p_expire) else $error("window end missed");
  property p_peak;
    (s.ph == lvd_pkg::LVD_PH_WIN && i_sample_valid && !s.clr_q) |=> s.peak >= $past(mag);
  endproperty
  a_peak: assert property (p_peak) else $error("peak below input");
  property p_sum;
    (s.ph == lvd_pkg::LVD_PH_WIN && i_sample_valid && !s.clr_q)
      |=> (s.sum == $past(s.sum) + 48'($past(mag)) && s.cnt == $past(s.cnt) + 32'h1);
  endproperty
  a_sum: assert property (p_sum) else $error("mean sum wrong");
  property p_sumsq;
    (s.ph == lvd_pkg::LVD_PH_WIN && i_sample_valid && !s.clr_q)
      |=> s.sumsq == $past(s.sumsq) + 64'($past(sq));
  endproperty
  a_sumsq: assert property (p_sumsq) else $error("square sum wrong");
  property p_fast;
    (expire && !s.clr_q) |=> s.fast == $past(s.last);
  endproperty
  a_fast: assert property (p_fast) else $error("fast value wrong");
  property p_scan;
    i_scan_step |-> ##2 (s.ph == lvd_pkg::LVD_PH_WIN && s.cnt == 32'h0);
  endproperty
  a_scan: assert property (p_scan) else $error("scan step did not clear");
  property p_init;
    (wr_cmd && i_wdata[`LVD_CMD_CONT]) |-> ##2 (s.ph == lvd_pkg::LVD_PH_WIN);
  endproperty
  a_init: assert property (p_init) else $error("initiate did not clear");
  property p_cycle;
    (s.ph == lvd_pkg::LVD_PH_HOLD && s.periodic && s.publish) |-> ##2 s.ph == lvd_pkg::LVD_PH_WIN;
  endproperty
  a_cycle: assert property (p_cycle) else $error("periodic clear missing");
  property p_norefresh;
    (s.periodic && $changed(s.result)) |-> s.publish;
  endproperty
  a_norefresh: assert property (p_norefresh) else $error("refresh in periodic");
  property p_invalid;
    (s.periodic && par_evt) |=> s.invalid;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid flag missing");
  property p_trace;
    (s.ph == lvd_pkg::LVD_PH_CALC && u_if.done && s.periodic && s.tren && !s.clr_q)
      |=> (s.wp == $past(s.wp) + 3'h1 && s.trace[$past(s.wp)] == s.result);
  endproperty
  a_trace: assert property (p_trace) else $error("trace not appended");
  property p_meas;
    (s.ph == lvd_pkg::LVD_PH_HOLD) |-> !o_measuring;
  endproperty
  a_meas: assert property (p_meas) else $error("measuring bit stuck");
  c_periodic: cover property (s.periodic && s.publish ##1 s.clr_q);
  c_refresh: cover property (!s.periodic && s.publish);
  c_user: cover property (s.user_en && expire);
  c_restart: cover property (s.ph == lvd_pkg::LVD_PH_CALC && s.clr_q);
endmodule

/* test/lvd_demod_model.sv */
// Sample source standing in for the demodulation datapath.
// Assumes the clock and reset of the timing block.
`timescale 1ns/1ps
module lvd_demod_model (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic [15:0] o_sample,
  output logic o_valid
);
  logic [1:0] ph;
  // Phase counter; a strobe every other cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) ph <= 2'h0;
    else ph <= ph + 2'h1;
  end
  // Magnitudes 100 and 300 alternate; between strobes the data is junk
  assign o_valid = ph[0];
  assign o_sample = !ph[0] ? {14'h1696, ph} : (ph[1] ? 16'hfed4 : 16'h0064);
endmodule

/* test/level_detector_timing_tb.sv */
// Testbench of the level detector timing block.
// Assumes lvd_cfg.svh on the include path and a short refresh parameter.
`timescale 1ns/1ps
`include "lvd_cfg.svh"
module level_detector_timing_tb;
  logic i_clk, i_rst, i_wr, i_rd, i_step, sv, o_inv, o_pub, o_meas, o_win;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [15:0] smp, o_result;
  int error_cnt, check_count;
  lvd_timing #(.P_REFRESH_US(5)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample(smp),
    .i_sample_valid(sv), .i_scan_step(i_step), .o_result(o_result),
    .o_result_invalid(o_inv), .o_publish(o_pub), .o_measuring(o_meas), .o_window(o_win));
  lvd_demod_model pm (.i_clk(i_clk), .i_rst(i_rst), .o_sample(smp), .o_valid(sv));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Bounded wait: publish pulse (p=1) or window idle (p=0)
  task wt(input bit p);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (!(p ? o_pub === 1'b1 : o_win === 1'b0) && n < 3000);
    chk("wait", 1, n < 3000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`LVD_REG_CTRL); chk("ctrl", 0, d);
    rd(`LVD_REG_UTIME); chk("utime", 32'h3e8, d);
    rd(`LVD_REG_STAT); chk("stat", 0, d);
    chk("meas pin", 0, o_meas);
    rd(8'h3c); chk("unmapped", 0, d);
  endtask
  // Default times per detector at the lowest bandwidth
  task automatic t_default;
    logic [31:0] c[4] = '{32'h0, 32'h4, 32'h8, 32'hc};
    logic [31:0] t[4] = '{32'h7a120, 32'h30d40, 32'h30d40, 32'h3e8};
    for (int i = 0; i < 4; i++) begin
      wr(`LVD_REG_CTRL, c[i]);
      rd(`LVD_REG_MTIME); chk("mtime", t[i], d);
      rd(`LVD_REG_MDTIME); chk("mdtime", t[i], d);
    end
  endtask
  // Each clear event must open a window two cycles on
  task ev(input int k);
    wt(0);
    case (k)
      0: wr(`LVD_REG_FREQ, 32'h1);
      1: begin
        @(posedge i_clk);
        i_step <= 1'b1;
        @(posedge i_clk);
        i_step <= 1'b0;
      end
      2: wr(`LVD_REG_TUNE, 32'h1);
      3: wr(`LVD_REG_TUNE, 32'h101);
      4: wr(`LVD_REG_TUNE, 32'h10101);
      5: wr(`LVD_REG_CTRL, 32'h14);
      default: wr(`LVD_REG_CMD, k - 5);
    endcase
    repeat (2) @(posedge i_clk);
    #1 chk("window", 1, o_win);
  endtask
  task t_clear;
    wr(`LVD_REG_CTRL, 32'h10);
    wr(`LVD_REG_UTIME, 32'h2);
    rd(`LVD_REG_RISE); chk("rise", 0, d);
    rd(`LVD_REG_FALL); chk("fall", 2, d);
    rd(`LVD_REG_DEVFALL); chk("devfall", 2, d);
    for (int k = 0; k < 8; k++) ev(k);
    rd(`LVD_REG_MTIME); chk("mtime", 2, d);
  endtask
  task t_cont;
    wr(`LVD_REG_CTRL, 32'h10);
    wt(1);
    wt(1);
    chk("cont", 300, o_result);
  endtask
  task t_periodic;
    wr(`LVD_REG_CTRL, 32'h13);
    wt(1);
    chk("peak", 300, o_result);
    chk("meas done", 0, o_meas);
    repeat (2) @(posedge i_clk);
    #1 chk("reclear", 1, o_win);
    chk("meas busy", 1, o_meas);
    rd(`LVD_REG_TRCNT); chk("trcnt", 32'h11, d);
    rd(8'h40); chk("trace", 300, d);
    wr(`LVD_REG_FREQ, 32'h5);
    @(posedge i_clk);
    #1 chk("invalid", 1, o_inv);
    wt(1);
    chk("valid", 0, o_inv);
    chk("query", 300, o_result);
  endtask
  // Means of alternating 100 and 300 with one odd sample of slack
  task t_means;
    wr(`LVD_REG_CTRL, 32'h17);
    wt(1);
    wt(1);
    chk("avg", 1, o_result >= 196 && o_result <= 204);
    wr(`LVD_REG_CTRL, 32'h1b);
    wt(1);
    wt(1);
    chk("rms", 1, o_result >= 220 && o_result <= 228);
    // Fast keeps one raw magnitude, never a mean of the two
    wr(`LVD_REG_CTRL, 32'h1f);
    wt(1);
    wt(1);
    chk("fast", 1, o_result == 100 || o_result == 300);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    error_cnt = 0;
    check_count = 0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_step = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_default;
    t_clear;
    t_cont;
    t_periodic;
    t_means;
    results;
  end
  // Watchdog: the run needs well under 50000 cycles
  initial begin
    #500000;
    error_cnt++;
    results;
  end
endmodule
